// File: design/ppb_pkg.sv
// Shared constants and types of the parallel panel bus master
package ppb_pkg;

  // ==========================================================
  // Data path
  localparam int DATA_W = 8;

  // ==========================================================
  // Clock and timing, times as printed, cycles derived
  localparam int CLK_PERIOD_NS   = 50;
  localparam int SETUP_NS        = 50;   // select/RS ahead of strobe
  localparam int WR_LOW_NS       = 100;  // store strobe low width
  localparam int RD_LOW_NS       = 250;  // read strobe low width
  localparam int HOLD_NS         = 50;   // after strobe rises
  localparam int INIT_LOW_US     = 10;   // panel reset pulse width
  localparam int INIT_WAIT_MS    = 120;  // panel recovery after reset
  localparam int SYNC_STAGES     = 2;

  function automatic int ns_to_min_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SETUP_CYC     = ns_to_min_cyc(SETUP_NS);
  localparam int WR_LOW_CYC    = ns_to_min_cyc(WR_LOW_NS);
  // Read data passes the pin synchroniser, so the strobe is stretched
  localparam int RD_LOW_CYC    = ns_to_min_cyc(RD_LOW_NS) + SYNC_STAGES;
  localparam int HOLD_CYC      = ns_to_min_cyc(HOLD_NS);
  localparam int INIT_LOW_CYC  = ns_to_min_cyc(INIT_LOW_US * 1000);
  localparam int INIT_WAIT_CYC = ns_to_min_cyc(INIT_WAIT_MS * 1000000);

  localparam int CNT_W = 24;

  // ==========================================================
  // Bus operations
  typedef enum logic [1:0] {
    OP_INDEX_WR,   // select low, RS low, store low
    OP_STATUS_RD,  // select low, RS low, read low
    OP_DATA_WR,    // select low, RS high, store low
    OP_MEM_RD      // select low, RS high, read low
  } ppb_op_e;

  typedef struct packed {
    ppb_op_e             op;
    logic [DATA_W-1:0]   data;
  } ppb_cmd_s;

  localparam int CMD_W = $bits(ppb_cmd_s);

  // Control pin levels
  localparam logic PIN_ON_N  = 1'b0;
  localparam logic PIN_OFF_N = 1'b1;

  function automatic logic op_is_read(input ppb_op_e op);
    return (op == OP_STATUS_RD) || (op == OP_MEM_RD);
  endfunction

  function automatic logic op_reg_sel(input ppb_op_e op);
    return (op == OP_DATA_WR) || (op == OP_MEM_RD);
  endfunction

endpackage

// File: design/ppb_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module ppb_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,  // system clock
  input  wire logic             sys_rst,  // async reset, high
  input  wire logic             inValid,  // writer offers a word
  output logic                  inReady,  // room for a word
  input  wire logic [WIDTH-1:0] inData,   // word written
  output logic                  outValid, // a word is held
  input  wire logic             outReady, // reader takes the word
  output logic      [WIDTH-1:0] outData   // oldest word
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("ppb_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// File: design/ppb_panel_master.sv
// 8-bit 80-series parallel bus master that drives a panel controller
//
// How it works
// RL1 - Eight-bit 80-series bus, all signals generated
// RL2 - Read strobe low only while reading
// RL3 - Store strobe low only while writing
// RL4 - Register select low for index/status
// RL5 - Register select high for data/memory
// RL6 - Panel select low only during accesses
// RL7 - Pulse panel reset low before any access
// RL8 - Strobe timing counted from the crystal clock
// RL9 - Operation encoding on select, RS, strobes
// RL10 - Data bus driven on writes, released on reads
// RL11 - Never both strobes; RS stable per strobe
`timescale 1ns/1ns
module ppb_panel_master
  import ppb_pkg::*;
#(
  parameter int FIFO_DEPTH    = 4,
  parameter int INIT_LOW_CNT  = ppb_pkg::INIT_LOW_CYC,
  parameter int INIT_WAIT_CNT = ppb_pkg::INIT_WAIT_CYC
) (
  input  wire logic                  clk_sys,          // buffered osc
  input  wire logic                  sys_rst,          // async reset
  input  wire logic                  crystalIn,        // crystal pin 1
  output logic                       crystalOut,       // crystal pin 2
  input  wire logic                  cmdValid,         // command offered
  output logic                       cmdReady,         // queue has room
  input  wire ppb_pkg::ppb_cmd_s     cmd,              // op and byte
  output logic                       rdValid,          // read byte pulse
  output logic [ppb_pkg::DATA_W-1:0] rdData,           // byte read back
  output logic                       panelReady,       // init finished
  output logic                       busBusy,          // access running
  output logic                       panelSelect_n,    // panel select
  output logic                       registerSelect,   // RS line
  output logic                       readStrobe_n,     // read strobe
  output logic                       storeStrobe_n,    // store strobe
  output logic                       panelInitPulse_n, // panel reset
  input  wire logic [ppb_pkg::DATA_W-1:0] panelDataIn, // bus pin in
  output logic [ppb_pkg::DATA_W-1:0] panelDataOut,     // bus pin out
  output logic                       panelDataOe_n     // low: driving
);
  import ppb_pkg::*;

  if (INIT_LOW_CNT < 1 || INIT_WAIT_CNT < 1 ||
      INIT_LOW_CNT >= (1 << CNT_W) || INIT_WAIT_CNT >= (1 << CNT_W))
  begin : g_chk
    $error("ppb_panel_master: init counts out of range");
  end
  if (FIFO_DEPTH < 2) begin : g_chk_fifo
    $error("ppb_panel_master: FIFO_DEPTH must be at least 2");
  end

  // ==========================================================
  // Oscillator
  // The crystal sits between the two pins; the inverter keeps it
  // running and clk_sys is the buffered result, so every strobe
  // width below is a count of its periods.
  assign crystalOut = ~crystalIn; // RL8

  // ==========================================================
  // Command queue
  ppb_cmd_s             qCmd;
  logic [CMD_W-1:0]     qBits;
  logic                 qValid;
  logic                 qReady;

  ppb_fifo #(
    .WIDTH (CMD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .inValid  (cmdValid),
    .inReady  (cmdReady),
    .inData   (CMD_W'(cmd)),
    .outValid (qValid),
    .outReady (qReady),
    .outData  (qBits)
  );

  assign qCmd = ppb_cmd_s'(qBits);

  // ==========================================================
  // Read data synchroniser
  // The panel drives the bus from its own timing, so the pins pass
  // two flops; the read strobe is stretched to cover the delay.
  logic [DATA_W-1:0] dataMeta;
  logic [DATA_W-1:0] dataSync;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dataMeta <= '0;
      dataSync <= '0;
    end else begin
      dataMeta <= panelDataIn;
      dataSync <= dataMeta;
    end
  end

  // ==========================================================
  // Sequencer
  typedef enum {
    ST_INIT_LOW,
    ST_INIT_WAIT,
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } ppb_state_e;

  ppb_state_e        state;
  ppb_state_e        next_state;
  logic [CNT_W-1:0]  cnt;
  logic              cntDone;
  ppb_cmd_s          cur;
  logic              curRead;

  assign cntDone = (cnt == '0);
  assign curRead = op_is_read(cur.op);
  // A command leaves the queue only once the bus is free and the
  // panel has come out of reset
  assign qReady  = (state == ST_IDLE); // RL7

  function automatic logic [CNT_W-1:0] load(input int cycles);
    return CNT_W'(cycles - 1);
  endfunction

  always_comb begin
    next_state = state;
    unique case (state)
      ST_INIT_LOW:  if (cntDone) next_state = ST_INIT_WAIT; // RL7
      ST_INIT_WAIT: if (cntDone) next_state = ST_IDLE; // RL7
      ST_IDLE:      if (qValid) next_state = ST_SETUP;
      ST_SETUP:     if (cntDone) next_state = ST_STROBE;
      ST_STROBE:    if (cntDone) next_state = ST_HOLD;
      ST_HOLD:      if (cntDone) next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_INIT_LOW;
    end else begin
      state <= next_state;
    end
  end

  // Phase counter, reloaded on every state change
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= CNT_W'(INIT_LOW_CNT - 1);
    end else if (next_state != state) begin
      unique case (next_state)
        ST_INIT_LOW:  cnt <= load(INIT_LOW_CNT);
        ST_INIT_WAIT: cnt <= load(INIT_WAIT_CNT);
        ST_SETUP:     cnt <= load(SETUP_CYC); // RL8
        ST_STROBE:    cnt <= load(curRead ? RD_LOW_CYC
                                          : WR_LOW_CYC); // RL8
        ST_HOLD:      cnt <= load(HOLD_CYC); // RL8
        ST_IDLE:      cnt <= '0;
      endcase
    end else if (!cntDone) begin
      cnt <= cnt - 1'b1;
    end
  end

  // Command latched at the start so RS cannot move under a strobe
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= '{op: OP_INDEX_WR, data: '0};
    end else if (qReady && qValid) begin
      cur <= qCmd; // RL11
    end
  end

  // ==========================================================
  // Panel pins, all registered
  logic accessOn;
  logic next_select_n;
  logic next_rs;
  logic next_rd_n;
  logic next_wr_n;
  logic next_oe_n;

  assign accessOn = (next_state == ST_SETUP) ||
                    (next_state == ST_STROBE) ||
                    (next_state == ST_HOLD);

  always_comb begin
    next_select_n = accessOn ? PIN_ON_N : PIN_OFF_N; // RL6
    next_rs       = accessOn ? op_reg_sel(next_state == ST_SETUP &&
                                          state == ST_IDLE ?
                                          qCmd.op : cur.op)
                             : registerSelect; // RL4 RL5 RL9 RL11
    next_rd_n     = PIN_OFF_N;
    next_wr_n     = PIN_OFF_N;
    if (next_state == ST_STROBE) begin
      if (curRead) begin
        next_rd_n = PIN_ON_N; // RL2 RL9 RL11
      end else begin
        next_wr_n = PIN_ON_N; // RL3 RL9 RL11
      end
    end
    // Driven for the whole write access, released for reads
    if (next_state == ST_SETUP && state == ST_IDLE) begin
      next_oe_n = op_is_read(qCmd.op) ? PIN_OFF_N : PIN_ON_N; // RL10
    end else if (accessOn) begin
      next_oe_n = curRead ? PIN_OFF_N : PIN_ON_N; // RL10
    end else begin
      next_oe_n = PIN_OFF_N;
    end
  end

  // Every pin is a flop, so all of them move on the same clock edge
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      panelSelect_n <= PIN_OFF_N;
    end else begin
      panelSelect_n <= next_select_n; // RL1 RL6
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      registerSelect <= 1'b0;
    end else begin
      registerSelect <= next_rs; // RL4 RL5
    end
  end

  // Strobes decode from one curRead test, so they can never be low together
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      readStrobe_n  <= PIN_OFF_N;
      storeStrobe_n <= PIN_OFF_N;
    end else begin
      readStrobe_n  <= next_rd_n; // RL2
      storeStrobe_n <= next_wr_n; // RL3
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      panelDataOe_n <= PIN_OFF_N;
    end else begin
      panelDataOe_n <= next_oe_n; // RL10
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      panelDataOut <= '0;
    end else if (qReady && qValid) begin
      panelDataOut <= qCmd.data; // RL1 RL10
    end
  end

  // Panel reset held low from system reset through the pulse
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      panelInitPulse_n <= PIN_ON_N;
    end else begin
      panelInitPulse_n <= (next_state == ST_INIT_LOW)
                          ? PIN_ON_N : PIN_OFF_N; // RL7
    end
  end

  // ==========================================================
  // Read result, sampled as the read strobe rises
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdValid <= 1'b0;
      rdData  <= '0;
    end else begin
      rdValid <= 1'b0;
      if (state == ST_STROBE && cntDone && curRead) begin
        rdValid <= 1'b1;
        rdData  <= dataSync; // RL2
      end
    end
  end

  // ==========================================================
  // Status
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      panelReady <= 1'b0;
    end else begin
      panelReady <= (next_state != ST_INIT_LOW) &&
                    (next_state != ST_INIT_WAIT); // RL7
    end
  end

  // Same source as the select flop, so both cover the same cycles
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busBusy <= 1'b0;
    end else begin
      busBusy <= accessOn;
    end
  end

endmodule

// File: verif/ppb_master_assertions.sv
// Pin-level assertions of the panel bus master
`timescale 1ns/1ns
module ppb_master_checker (
  input wire logic clk_sys,          // clock
  input wire logic sys_rst,          // reset
  input wire logic panelSelect_n,    // select
  input wire logic registerSelect,   // RS
  input wire logic readStrobe_n,     // read strobe
  input wire logic storeStrobe_n,    // store strobe
  input wire logic panelDataOe_n,    // bus enable
  input wire logic busBusy,          // access flag
  input wire logic panelReady,       // init done
  input wire logic panelInitPulse_n, // panel reset
  input wire logic rdValid           // read pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Strobes, select and init order
  strobe_excl_a: assert property (readStrobe_n || storeStrobe_n)
    else $error("both strobes low");
  strobe_in_sel_a: assert property (!(readStrobe_n && storeStrobe_n)
    |-> !panelSelect_n) else $error("strobe outside select");
  sel_setup_a: assert property ($fell(panelSelect_n)
    |-> readStrobe_n && storeStrobe_n) else $error("no setup cycle");
  rs_stable_a: assert property (!panelSelect_n && !$past(panelSelect_n)
    |-> $stable(registerSelect)) else $error("RS moved in access");
  wr_width_a: assert property ($fell(storeStrobe_n)
    |=> !storeStrobe_n ##1 storeStrobe_n) else $error("store width");
  rd_width_a: assert property ($fell(readStrobe_n)
    |=> !readStrobe_n [*6] ##1 readStrobe_n) else $error("read width");
  wr_drive_a: assert property (!storeStrobe_n |-> !panelDataOe_n)
    else $error("bus not driven on write");
  rd_release_a: assert property (!readStrobe_n |-> panelDataOe_n)
    else $error("bus driven on read");
  rd_valid_a: assert property (rdValid == $rose(readStrobe_n))
    else $error("read pulse misplaced");
  init_gate_a: assert property (!panelReady |-> panelSelect_n)
    else $error("access before init");
  init_order_a: assert property (panelReady |-> panelInitPulse_n)
    else $error("ready while panel reset low");
  busy_sel_a: assert property (busBusy == !panelSelect_n)
    else $error("busy differs from select");
endmodule
bind ppb_panel_master ppb_master_checker chk (.clk_sys, .sys_rst,
  .panelSelect_n, .registerSelect, .readStrobe_n, .storeStrobe_n,
  .panelDataOe_n, .busBusy, .panelReady, .panelInitPulse_n, .rdValid);

// File: verif/ppb_panel_model.sv
// Behavioural panel controller on the far side of the bus
`timescale 1ns/1ns
module ppb_panel_model #(
  parameter logic [7:0] STATUS = 8'h3c, // status byte, arbitrary
  parameter int         LAT_NS = 200    // read access time
) (
  input  wire logic       panelSelect_n,  // select
  input  wire logic       registerSelect, // RS
  input  wire logic       readStrobe_n,   // read strobe
  input  wire logic       storeStrobe_n,  // store strobe
  input  wire logic       panelDataOe_n,  // master drives
  input  wire logic [7:0] panelDataOut,   // master byte
  output logic      [7:0] panelDataIn     // wire level
);
  logic [8:0] wrLog[$];
  logic [7:0] memByte = 8'h00;
  logic [7:0] held = 8'h00;
  logic       drive = 1'b0;
  // ==========================================================
  // Writes land on the rising store strobe
  always @(posedge storeStrobe_n)
    if (panelSelect_n === 1'b0) begin
      wrLog.push_back({registerSelect, panelDataOut});
      if (registerSelect) memByte = panelDataOut;
    end
  // Data valid only after the access time, never before
  always @(negedge readStrobe_n) begin
    drive = 1'b0;
    #LAT_NS drive = !readStrobe_n && !panelSelect_n;
  end
  // Released bus shows the inverse, no keeper on the lines
  always @(posedge readStrobe_n) begin
    held = panelDataIn;
    drive = 1'b0;
  end
  always @(posedge panelDataOe_n) held = panelDataOut;
  assign panelDataIn = !panelDataOe_n ? panelDataOut :
                       drive ? (registerSelect ? memByte : STATUS) :
                       ~held;
endmodule

// File: verif/testbench.sv
// Self-checking bench of the panel bus master
`timescale 1ns/1ns
module testbench;
  import ppb_pkg::*;
  localparam int         LOW_CNT  = 4;
  localparam int         WAIT_CNT = 20;
  localparam logic [7:0] ST_BYTE  = 8'h3c;
  typedef struct {ppb_op_e op; logic [7:0] d; logic rs; logic [7:0] e;}
    ppb_row_s;
  logic        clk_sys, sys_rst, crystalIn, cmdValid, cmdReady, crystalOut;
  logic        rdValid, panelReady, busBusy, panelSelect_n, registerSelect;
  logic        readStrobe_n, storeStrobe_n, panelInitPulse_n, panelDataOe_n;
  ppb_cmd_s    cmd;
  logic [7:0]  rdData, panelDataIn, panelDataOut, got;
  int          miscompares = 0;
  int          nTests = 0;
  int          nLog, k, pulses;
  bit          refused;
  ppb_row_s    rows[8] = '{'{OP_INDEX_WR, 8'h2c, 0, 0},
    '{OP_DATA_WR, 8'ha5, 1, 0}, '{OP_MEM_RD, 0, 1, 8'ha5},
    '{OP_STATUS_RD, 0, 0, ST_BYTE}, '{OP_DATA_WR, 8'hff, 1, 0},
    '{OP_MEM_RD, 0, 1, 8'hff}, '{OP_DATA_WR, 8'h00, 1, 0},
    '{OP_MEM_RD, 0, 1, 8'h00}};

  ppb_panel_master #(.INIT_LOW_CNT(LOW_CNT), .INIT_WAIT_CNT(WAIT_CNT)) DUT (
    .clk_sys, .sys_rst, .crystalIn, .crystalOut, .cmdValid, .cmdReady, .cmd,
    .rdValid, .rdData, .panelReady, .busBusy, .panelSelect_n,
    .registerSelect, .readStrobe_n, .storeStrobe_n, .panelInitPulse_n,
    .panelDataIn, .panelDataOut, .panelDataOe_n);
  ppb_panel_model #(.STATUS(ST_BYTE)) panel (.panelSelect_n, .registerSelect,
    .readStrobe_n, .storeStrobe_n, .panelDataOe_n, .panelDataOut,
    .panelDataIn);

  initial begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // Helpers
  task automatic chk1(string name, logic exp, logic seen);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", name, exp, seen);
    end
  endtask
  task automatic chk8(string name, logic [7:0] exp, logic [7:0] seen);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk_sys);
    #5;
  endtask
  task automatic send(ppb_op_e op, logic [7:0] d);
    cmdValid = 1;
    cmd = '{op, d};
    while (cmdReady !== 1'b1) tick();
    tick();
    cmdValid = 0;
  endtask
  // Waits for one access to open and close, catching any read pulse
  task automatic settle;
    bit seen;
    seen = 0;
    pulses = 0;
    repeat (40) begin
      tick();
      if (rdValid === 1'b1) begin
        pulses++;
        got = rdData;
      end
      if (busBusy === 1'b1) seen = 1;
      else if (seen) break;
    end
  endtask
  task automatic waitReady;
    int n;
    n = 0;
    tick();
    chk1("init pulse low", 1'b0, panelInitPulse_n);
    while (panelReady !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    chk1("ready delay", 1'b1, n == LOW_CNT + WAIT_CNT - 1);
    chk1("init pulse high", 1'b1, panelInitPulse_n);
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  initial begin
    sys_rst = 1;
    cmdValid = 0;
    cmd = '0;
    crystalIn = 0;
    repeat (3) @(posedge clk_sys);
    #5;
    chk1("reset select", 1'b1, panelSelect_n);
    chk1("reset strobe", 1'b1, readStrobe_n & storeStrobe_n);
    chk1("crystal low", 1'b1, crystalOut);
    crystalIn = 1;
    sys_rst = 0;
    #1 chk1("crystal high", 1'b0, crystalOut);
    waitReady();
    foreach (rows[i]) begin
      nLog = panel.wrLog.size();
      send(rows[i].op, rows[i].d);
      settle();
      chk1("rs level", rows[i].rs, registerSelect);
      if (rows[i].op inside {OP_INDEX_WR, OP_DATA_WR}) begin
        chk1("write logged", 1, panel.wrLog.size() == nLog + 1);
        chk8("write byte", rows[i].d, panel.wrLog[nLog][7:0]);
        chk1("write rs", rows[i].rs, panel.wrLog[nLog][8]);
        chk1("no read pulse", 1, pulses == 0);
      end else begin
        chk1("one read pulse", 1, pulses == 1);
        chk8("read byte", rows[i].e, got);
      end
    end
    // Burst past the queue depth, then all bytes in order
    nLog = panel.wrLog.size();
    refused = 0;
    k = 0;
    cmdValid = 1;
    while (k < 6) begin
      cmd = '{OP_DATA_WR, 8'h10 + 8'(k)};
      if (cmdReady === 1'b1) k++;
      else refused = 1;
      tick();
    end
    cmdValid = 0;
    chk1("queue refused", 1'b1, refused);
    repeat (80) if (panel.wrLog.size() < nLog + 6) tick();
    for (k = 0; k < 6; k++)
      chk8("burst byte", 8'h10 + 8'(k), panel.wrLog[nLog + k][7:0]);
    // Reset in mid-write must drop the bus at once
    send(OP_INDEX_WR, 8'h77);
    repeat (20) if (storeStrobe_n !== 1'b0) tick();
    sys_rst = 1;
    #1 chk1("abort strobe", 1'b1, storeStrobe_n);
    chk1("abort select", 1'b1, panelSelect_n);
    chk1("abort init", 1'b0, panelInitPulse_n);
    tick();
    sys_rst = 0;
    waitReady();
    // The bus must work again after the abort
    nLog = panel.wrLog.size();
    send(OP_DATA_WR, 8'h5a);
    settle();
    chk8("after abort", 8'h5a, panel.wrLog[nLog][7:0]);
    conclude();
  end
endmodule
